/* shared/sps_defs.vh */
`ifndef SPS_DEFS_VH
`define SPS_DEFS_VH

// clock and common time base
`define SPS_CLK_NS          10
`define SPS_TICK_US         16
`define SPS_TICK_CYC        ((`SPS_TICK_US * 1000) / `SPS_CLK_NS)
`define SPS_TW              20

// pause timer and external-input timeout
`define SPS_PAUSE_BASE_US   512
`define SPS_PAUSE_BASE_TK   (`SPS_PAUSE_BASE_US / `SPS_TICK_US)
`define SPS_TIMEOUT_MS      500
`define SPS_TIMEOUT_TK      ((`SPS_TIMEOUT_MS * 1000) / `SPS_TICK_US)

// reset release unit 1.024 ms, linear range end
`define SPS_RST_UNIT_US     1024
`define SPS_RST_UNIT_TK     (`SPS_RST_UNIT_US / `SPS_TICK_US)
`define SPS_RST_LIN_MAX     31
`define SPS_RST_MULT        32

// oscillator stabilization times in ms
`define SPS_STAB1_MS        520
`define SPS_STAB2_MS        1000
`define SPS_STAB3_MS        1500
`define SPS_STAB4_MS        2100
`define SPS_STAB5_MS        2600
`define SPS_STAB6_MS        3100
`define SPS_STAB7_MS        3600
`define SPS_MS_TK(ms)       (((ms) * 1000) / `SPS_TICK_US)
`define SPS_OSC_START_FALLS 3

// register offsets
`define SPS_ADDR_STEPS      8'h92
`define SPS_ADDR_PAUSE      8'h97
`define SPS_ADDR_OSC        8'h98
`define SPS_ADDR_RST        8'h99

// reset values
`define SPS_RST_STEPS       8'h00
`define SPS_RST_PAUSE       8'h00
`define SPS_RST_OSC         8'h00
`define SPS_RST_RSTREG      8'h00

// step register fields
`define SPS_F_CLKSTEP       7:4
`define SPS_F_PAUSESTEP     3:0
// pause register fields
`define SPS_F_DIR           7:6
`define SPS_B_TIMEOUT       5
`define SPS_B_MODE          4
`define SPS_F_PTIME         3:0
// oscillator register fields
`define SPS_B_OUTEN         7
`define SPS_B_RTCGATE       6
`define SPS_B_OUTGATE       5
`define SPS_B_DLYMODE       4
`define SPS_B_CRYSTAL       3
`define SPS_F_STAB          2:0
// reset register fields
`define SPS_F_EVENT         7:6
`define SPS_F_RTIME         5:0

// reset start events
`define SPS_EV_WAKE         2'h0
`define SPS_EV_SYS          2'h1
`define SPS_EV_PWR          2'h2
`define SPS_EV_RSTEXIT      2'h3

`endif

/* design/sps_tick_div.v */
`timescale 1ns/1ps
`default_nettype none
module sps_tick_div #(
	parameter DIV = 1600
) (
	// clock and reset
	input  wire        clock_i,
	input  wire        rst_b_i,
	// control
	input  wire        restart_i,
	output reg         tick_o
);
	reg [15:0] cnt;

	// restart aligns the first tick to a full period after a load
	always @(posedge clock_i) begin
		if (!rst_b_i || restart_i) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b0;
		end else if (cnt == DIV[15:0] - 16'h0001) begin
			cnt    <= 16'h0000;
			tick_o <= 1'b1;
		end else begin
			cnt    <= cnt + 16'h0001;
			tick_o <= 1'b0;
		end
	end
endmodule // sps_tick_div
`default_nettype wire

/* design/sps_timer.v */
`timescale 1ns/1ps
`default_nettype none
`include "sps_defs.vh"
module sps_timer (
	// clock and reset
	input  wire               clock_i,
	input  wire               rst_b_i,
	// control
	input  wire               load_i,
	input  wire               stop_i,
	input  wire [`SPS_TW-1:0] len_i,
	input  wire               tick_i,
	// status
	output wire               busy_o,
	output reg                done_o
);
	reg [`SPS_TW-1:0] remain;

	assign busy_o = (remain != {`SPS_TW{1'b0}});

	always @(posedge clock_i) begin
		if (!rst_b_i || stop_i) begin
			remain <= {`SPS_TW{1'b0}};
			done_o <= 1'b0;
		end else if (load_i) begin
			remain <= len_i;
			done_o <= 1'b0;
		end else if (tick_i && busy_o) begin
			remain <= remain - {{(`SPS_TW-1){1'b0}}, 1'b1};
			done_o <= (remain == {{(`SPS_TW-1){1'b0}}, 1'b1});
		end else begin
			done_o <= 1'b0;
		end
	end
endmodule // sps_timer
`default_nettype wire

/* design/sps_timing_ctrl.v */
// Functional notes
// RULE1 - direction field: never, up only, down only, or both directions
// RULE2 - mode clear: hold at pause step until sync input is active
// RULE3 - mode set: start internal timer at pause step, hold until expiry
// RULE4 - timeout bit limits external wait to 500 ms; ignored in timer mode
// RULE5 - pause time doubles per code from 512 us up to 8.4 s
// RULE6 - pause code zero adds no delay beyond normal slot time
// RULE7 - output enable bit drives slow clock onto outputs, possibly delayed
// RULE8 - counter gating withholds crystal clock from counter until stable
// RULE9 - output gating withholds crystal clock from outputs until stable
// RULE10 - stabilization start: third falling edge, or oscillator switch-on
// RULE11 - crystal-present bit loaded from backup domain at core reset
// RULE12 - stabilization code: 000 none, then about 0.5 s steps to 3.6 s
// RULE13 - event select: wake, system up, power up, or leaving reset mode
// RULE14 - reset timer zero releases system reset right after the event
// RULE15 - reset timer 1 to 31 delays by value times 1.024 ms
// RULE16 - reset timer 32 to 63 delays 1.024 ms times 32 times (value-31)
// RULE17 - pause acts at the step held in the pause step field
// RULE18 - slow clocks are enabled at the step held in clock step field
// RULE19 - once pause condition is met the sequencer moves to next slot
// RULE20 - host must drive sync input active, else stall without timeout
`timescale 1ns/1ps
`default_nettype none
`include "sps_defs.vh"
module sps_timing_ctrl #(
	parameter TICK_CYC = `SPS_TICK_CYC
) (
	// clock and reset
	input  wire       clock_i,
	input  wire       rst_b_i,
	// register port
	input  wire [7:0] reg_addr_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	input  wire [7:0] reg_wdata_i,
	output reg  [7:0] reg_rdata_o,
	// sequencer
	input  wire       seq_step_start_i,
	input  wire [3:0] seq_step_i,
	input  wire       seq_dir_up_i,
	output reg        seq_hold_o,
	// host side
	input  wire       sync_input_pin_i,
	output reg        system_reset_n_o,
	// reset release events
	input  wire       external_wake_event_i,
	input  wire       system_domain_up_i,
	input  wire       power_domain_up_i,
	input  wire       reset_mode_exit_i,
	input  wire       reset_mode_enter_i,
	// oscillator
	input  wire       backup_crystal_i,
	input  wire       osc_on_i,
	input  wire       osc_clk_i,
	output reg        rtc_clock_o,
	output reg        slow_clock_output_o
);
	localparam P_IDLE  = 2'd0;
	localparam P_TIMER = 2'd1;
	localparam P_EXT   = 2'd2;

	reg  [7:0]         steps_reg, pause_reg, osc_reg, rst_reg;
	reg  [1:0]         pstate, next_pstate, falls;
	reg                crystal_pending, clk_step_reached;
	reg                stab_expired, rst_pending;
	reg                next_hold, p_load, stab_load, ev_hit;
	reg                osc_on_q, osc_clk_q;
	reg  [`SPS_TW-1:0] p_len, stab_len, r_len;
	reg  [31:0]        stab_ticks;
	wire               p_tick, s_tick, r_tick;
	wire               p_done, s_done, r_done;
	wire               r_load, dir_ok, at_pause, stab_ok;
	wire [31:0]        p_ticks, to_ticks, r_ticks;
	wire [5:0]         rtime;

	// register writes; crystal bit fetched once after reset release
	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			steps_reg       <= `SPS_RST_STEPS;
			pause_reg       <= `SPS_RST_PAUSE;
			osc_reg         <= `SPS_RST_OSC;
			rst_reg         <= `SPS_RST_RSTREG;
			crystal_pending <= 1'b1;
		end else begin
			crystal_pending <= 1'b0;
			if (reg_wr_i && reg_addr_i == `SPS_ADDR_STEPS) begin
				steps_reg <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == `SPS_ADDR_PAUSE) begin
				pause_reg <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == `SPS_ADDR_OSC) begin
				osc_reg <= reg_wdata_i;
			end
			if (crystal_pending) begin
				osc_reg[`SPS_B_CRYSTAL] <= backup_crystal_i; // RULE11
			end
			if (reg_wr_i && reg_addr_i == `SPS_ADDR_RST) begin
				rst_reg <= reg_wdata_i;
			end
		end
	end

	// unmapped addresses read as zero
	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			case (reg_addr_i)
				`SPS_ADDR_STEPS: reg_rdata_o <= steps_reg;
				`SPS_ADDR_PAUSE: reg_rdata_o <= pause_reg;
				`SPS_ADDR_OSC:   reg_rdata_o <= osc_reg;
				`SPS_ADDR_RST:   reg_rdata_o <= rst_reg;
				default:         reg_rdata_o <= 8'h00;
			endcase
		end
	end

	// pause step
	assign dir_ok = seq_dir_up_i ? pause_reg[6] : pause_reg[7]; // RULE1
	assign at_pause = seq_step_start_i && dir_ok &&
		(seq_step_i == steps_reg[`SPS_F_PAUSESTEP]); // RULE17
	assign p_ticks = `SPS_PAUSE_BASE_TK <<
		(pause_reg[`SPS_F_PTIME] - 4'h1); // RULE5
	assign to_ticks = `SPS_TIMEOUT_TK; // RULE4

	always @* begin
		next_pstate = pstate;
		next_hold   = seq_hold_o;
		p_load      = 1'b0;
		p_len       = p_ticks[`SPS_TW-1:0];
		case (pstate)
			P_IDLE: begin
				if (at_pause && pause_reg[`SPS_B_MODE]) begin
					// code zero: ordinary slot time only
					if (pause_reg[`SPS_F_PTIME] != 4'h0) begin // RULE6
						next_pstate = P_TIMER; // RULE3
						next_hold   = 1'b1;
						p_load      = 1'b1;
					end
				end else if (at_pause && !sync_input_pin_i) begin
					next_pstate = P_EXT; // RULE2
					next_hold   = 1'b1;
					p_load      = pause_reg[`SPS_B_TIMEOUT]; // RULE4
					p_len       = to_ticks[`SPS_TW-1:0];
				end
			end
			P_TIMER: begin
				if (p_done) begin
					next_pstate = P_IDLE; // RULE19
					next_hold   = 1'b0;
				end
			end
			P_EXT: begin
				// without timeout this waits on the host forever
				if (sync_input_pin_i || p_done) begin // RULE20
					next_pstate = P_IDLE; // RULE19
					next_hold   = 1'b0;
				end
			end
			default: begin
				next_pstate = P_IDLE;
				next_hold   = 1'b0;
			end
		endcase
	end

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			pstate     <= P_IDLE;
			seq_hold_o <= 1'b0;
		end else begin
			pstate     <= next_pstate;
			seq_hold_o <= next_hold;
		end
	end

	sps_tick_div #(.DIV(TICK_CYC)) u_ptick (
		.clock_i   (clock_i),
		.rst_b_i   (rst_b_i),
		.restart_i (p_load),
		.tick_o    (p_tick)
	);

	sps_timer u_ptimer (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.load_i  (p_load),
		.stop_i  (next_pstate == P_IDLE),
		.len_i   (p_len),
		.tick_i  (p_tick),
		.busy_o  (),
		.done_o  (p_done)
	);

	// oscillator stabilization
	always @* begin
		case (osc_reg[`SPS_F_STAB]) // RULE12
			3'd1:    stab_ticks = `SPS_MS_TK(`SPS_STAB1_MS);
			3'd2:    stab_ticks = `SPS_MS_TK(`SPS_STAB2_MS);
			3'd3:    stab_ticks = `SPS_MS_TK(`SPS_STAB3_MS);
			3'd4:    stab_ticks = `SPS_MS_TK(`SPS_STAB4_MS);
			3'd5:    stab_ticks = `SPS_MS_TK(`SPS_STAB5_MS);
			3'd6:    stab_ticks = `SPS_MS_TK(`SPS_STAB6_MS);
			3'd7:    stab_ticks = `SPS_MS_TK(`SPS_STAB7_MS);
			default: stab_ticks = 32'h0000_0000;
		endcase
		stab_len = stab_ticks[`SPS_TW-1:0];
	end

	always @* begin
		if (osc_reg[`SPS_B_DLYMODE]) begin
			stab_load = osc_on_i && !osc_on_q; // RULE10
		end else begin
			stab_load = osc_on_i && osc_clk_q && !osc_clk_i &&
				(falls == `SPS_OSC_START_FALLS - 1); // RULE10
		end
	end

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			osc_on_q     <= 1'b0;
			osc_clk_q    <= 1'b0;
			falls        <= 2'd0;
			stab_expired <= 1'b0;
		end else begin
			osc_on_q  <= osc_on_i;
			osc_clk_q <= osc_clk_i;
			if (!osc_on_i) begin
				falls        <= 2'd0;
				stab_expired <= 1'b0;
			end else begin
				// saturate so a late mode change cannot restart
				if (osc_clk_q && !osc_clk_i && falls != 2'd3) begin
					falls <= falls + 2'd1;
				end
				if (s_done) begin
					stab_expired <= 1'b1;
				end
			end
		end
	end

	assign stab_ok = osc_on_i && (stab_expired ||
		osc_reg[`SPS_F_STAB] == 3'd0); // RULE12

	sps_tick_div #(.DIV(TICK_CYC)) u_stick (
		.clock_i   (clock_i),
		.rst_b_i   (rst_b_i),
		.restart_i (stab_load),
		.tick_o    (s_tick)
	);

	sps_timer u_stimer (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.load_i  (stab_load),
		.stop_i  (!osc_on_i),
		.len_i   (stab_len),
		.tick_i  (s_tick),
		.busy_o  (),
		.done_o  (s_done)
	);

	// slow clock distribution, one cycle behind the oscillator
	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			clk_step_reached    <= 1'b0;
			rtc_clock_o         <= 1'b0;
			slow_clock_output_o <= 1'b0;
		end else begin
			if (seq_step_start_i &&
				seq_step_i == steps_reg[`SPS_F_CLKSTEP]) begin
				clk_step_reached <= seq_dir_up_i; // RULE18
			end
			rtc_clock_o <= clk_step_reached && osc_clk_i &&
				(!osc_reg[`SPS_B_RTCGATE] || stab_ok); // RULE8
			slow_clock_output_o <= clk_step_reached && osc_clk_i &&
				osc_reg[`SPS_B_OUTEN] && // RULE7
				(!osc_reg[`SPS_B_OUTGATE] || stab_ok); // RULE9
		end
	end

	// reset release timer
	assign rtime = rst_reg[`SPS_F_RTIME];
	assign r_ticks = (rtime <= `SPS_RST_LIN_MAX) ?
		`SPS_RST_UNIT_TK * rtime : // RULE15
		`SPS_RST_UNIT_TK * `SPS_RST_MULT *
		(rtime - `SPS_RST_LIN_MAX); // RULE16
	always @* begin
		r_len = r_ticks[`SPS_TW-1:0];
		case (rst_reg[`SPS_F_EVENT]) // RULE13
			`SPS_EV_WAKE:    ev_hit = external_wake_event_i;
			`SPS_EV_SYS:     ev_hit = system_domain_up_i;
			`SPS_EV_PWR:     ev_hit = power_domain_up_i;
			`SPS_EV_RSTEXIT: ev_hit = reset_mode_exit_i;
			default:         ev_hit = 1'b0;
		endcase
	end
	assign r_load = ev_hit && !system_reset_n_o && !reset_mode_enter_i;

	always @(posedge clock_i) begin
		if (!rst_b_i) begin
			system_reset_n_o <= 1'b0;
			rst_pending      <= 1'b0;
		end else if (reset_mode_enter_i) begin
			system_reset_n_o <= 1'b0;
			rst_pending      <= 1'b0;
		end else if (r_load && rtime == 6'h00) begin
			system_reset_n_o <= 1'b1; // RULE14
		end else if (r_load) begin
			rst_pending <= 1'b1;
		end else if (rst_pending && r_done) begin
			rst_pending      <= 1'b0;
			system_reset_n_o <= 1'b1; // RULE15
		end
	end

	sps_tick_div #(.DIV(TICK_CYC)) u_rtick (
		.clock_i   (clock_i),
		.rst_b_i   (rst_b_i),
		.restart_i (r_load),
		.tick_o    (r_tick)
	);

	sps_timer u_rtimer (
		.clock_i (clock_i),
		.rst_b_i (rst_b_i),
		.load_i  (r_load),
		.stop_i  (reset_mode_enter_i),
		.len_i   (r_len),
		.tick_i  (r_tick),
		.busy_o  (),
		.done_o  (r_done)
	);
endmodule // sps_timing_ctrl
`default_nettype wire

/* sim/sps_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sps_host_model (
	// clock
	input  wire logic        clock_i,
	// bench control
	input  wire logic        ready_i,
	input  wire logic [15:0] lag_i,
	// to device
	output var  logic        sync_o
);
	logic [15:0] wait_cnt;
	always @(posedge clock_i) begin
		if (!ready_i)
			wait_cnt <= 16'h0000;
		else if (wait_cnt != 16'hffff)
			wait_cnt <= wait_cnt + 16'h0001;
	end
	// lag_i sets a prompt or a slow host
	always_comb sync_o = ready_i && wait_cnt >= lag_i;
endmodule // sps_host_model
`default_nettype wire

/* sim/sps_timing_ctrl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module sps_timing_ctrl_chk #(
	parameter TICK_CYC = 1600
) (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rst_b_i,
	// register port
	input wire logic [7:0] reg_addr_i,
	input wire logic       reg_wr_i,
	input wire logic [7:0] reg_wdata_i,
	// sequencer and host
	input wire logic       seq_step_start_i,
	input wire logic [3:0] seq_step_i,
	input wire logic       seq_dir_up_i,
	input wire logic       seq_hold_o,
	input wire logic       sync_input_pin_i,
	input wire logic       system_reset_n_o,
	input wire logic       external_wake_event_i,
	input wire logic       reset_mode_enter_i,
	// oscillator
	input wire logic       osc_on_i,
	input wire logic       osc_clk_i,
	input wire logic       rtc_clock_o,
	input wire logic       slow_clock_output_o
);
	// shadow copy, built from port writes only
	logic [7:0] sh [0:15];
	wire  [7:0] st = sh[2];
	wire  [7:0] pr = sh[7];
	wire  [7:0] oc = sh[8];
	wire  [7:0] rr = sh[9];
	wire        take = seq_step_start_i && !seq_hold_o
		&& seq_step_i == st[3:0] && (seq_dir_up_i ? pr[6] : pr[7]);
	always @(posedge clock_i) begin
		for (int k = 0; k < 16; k++) begin
			if (!rst_b_i)
				sh[k] <= 8'h00;
			else if (reg_wr_i && reg_addr_i == {4'h9, k[3:0]})
				sh[k] <= reg_wdata_i;
		end
	end
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	AST_WAKE_ZERO: assert property (
		!system_reset_n_o && !reset_mode_enter_i && rr == 8'h00
		&& external_wake_event_i |=> system_reset_n_o)
		else $error("reset not released after wake event");
	AST_EXT_HOLD: assert property (
		take && !pr[4] && !sync_input_pin_i |=> seq_hold_o)
		else $error("no hold while sync input low");
	AST_EXT_STAY: assert property (
		seq_hold_o && pr[5:4] == 2'b00 && !sync_input_pin_i |=> seq_hold_o)
		else $error("hold dropped without sync or timeout");
	AST_EXT_GO: assert property (
		seq_hold_o && !pr[4] && sync_input_pin_i |-> ##[1:2] !seq_hold_o)
		else $error("hold kept after sync input");
	AST_TMR_HOLD: assert property (
		take && pr[4] && pr[3:0] != 4'h0 |=> seq_hold_o [*2])
		else $error("no hold in timer mode");
	AST_TMR_ZERO: assert property (
		seq_step_start_i && !seq_hold_o && pr[4] && pr[3:0] == 4'h0
		|=> !seq_hold_o [*2])
		else $error("hold with pause code zero");
	AST_OUT_SRC: assert property (
		slow_clock_output_o |-> $past(osc_clk_i) && $past(oc[7]))
		else $error("clock output without source or enable");
	AST_RTC_GATE: assert property (
		$rose(osc_on_i) && oc[6] && oc[2:0] != 3'h0 |=> !rtc_clock_o [*8])
		else $error("counter clock before stable");
	AST_OUT_GATE: assert property (
		$rose(osc_on_i) && oc[5] && oc[2:0] != 3'h0
		|=> !slow_clock_output_o [*8])
		else $error("output clock before stable");
	cover property (take);
	cover property ($rose(system_reset_n_o));
	cover property ($rose(slow_clock_output_o));
endmodule // sps_timing_ctrl_chk
bind sps_timing_ctrl sps_timing_ctrl_chk #(.TICK_CYC(TICK_CYC)) u_chk (
	.clock_i               (clock_i),
	.rst_b_i               (rst_b_i),
	.reg_addr_i            (reg_addr_i),
	.reg_wr_i              (reg_wr_i),
	.reg_wdata_i           (reg_wdata_i),
	.seq_step_start_i      (seq_step_start_i),
	.seq_step_i            (seq_step_i),
	.seq_dir_up_i          (seq_dir_up_i),
	.seq_hold_o            (seq_hold_o),
	.sync_input_pin_i      (sync_input_pin_i),
	.system_reset_n_o      (system_reset_n_o),
	.external_wake_event_i (external_wake_event_i),
	.reset_mode_enter_i    (reset_mode_enter_i),
	.osc_on_i              (osc_on_i),
	.osc_clk_i             (osc_clk_i),
	.rtc_clock_o           (rtc_clock_o),
	.slow_clock_output_o   (slow_clock_output_o)
);
`default_nettype wire

/* sim/sps_timing_ctrl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module sps_timing_ctrl_tb;
	logic        clock_i, rst_b_i, reg_wr_i, reg_rd_i, step_i, up_i;
	logic [7:0]  addr_i, wdata_i, rdata_o;
	logic [3:0]  stp_i, ev_p;
	logic        hold_o, sync, rst_n_o, enter_i, osc_on_i, osc_i;
	logic        rtc_o, out_o, ready;
	logic [15:0] lag;
	int          err_total, tests_run, n;
	sps_timing_ctrl #(.TICK_CYC(2)) u_sps_timing_ctrl (
		.clock_i(clock_i), .rst_b_i(rst_b_i),
		.reg_addr_i(addr_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
		.reg_wdata_i(wdata_i), .reg_rdata_o(rdata_o),
		.seq_step_start_i(step_i), .seq_step_i(stp_i),
		.seq_dir_up_i(up_i), .seq_hold_o(hold_o),
		.sync_input_pin_i(sync), .system_reset_n_o(rst_n_o),
		.external_wake_event_i(ev_p[0]), .system_domain_up_i(ev_p[1]),
		.power_domain_up_i(ev_p[2]), .reset_mode_exit_i(ev_p[3]),
		.reset_mode_enter_i(enter_i), .backup_crystal_i(1'b1),
		.osc_on_i(osc_on_i), .osc_clk_i(osc_i),
		.rtc_clock_o(rtc_o), .slow_clock_output_o(out_o));
	sps_host_model u_sps_host_model (.clock_i(clock_i), .ready_i(ready),
		.lag_i(lag), .sync_o(sync));
	initial begin
		clock_i = 1'b0;
		forever #5 clock_i = ~clock_i;
	end
	initial begin
		osc_i = 1'b0;
		forever begin
			repeat (6) @(posedge clock_i);
			#1 osc_i = ~osc_i;
		end
	end
	task automatic tick(input int k);
		repeat (k) @(posedge clock_i);
		#1;
	endtask
	task automatic chk(input string s, input logic [7:0] e, g);
		tests_run++;
		if (g !== e) begin
			$display("BAD %s exp %0h got %0h", s, e, g);
			err_total++;
		end
	endtask
	task automatic rng(input string s, input int lo, hi, g);
		tests_run++;
		if (g < lo || g > hi) begin
			$display("BAD %s exp %0d..%0d got %0d", s, lo, hi, g);
			err_total++;
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		addr_i = a;
		wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		// idle cycle keeps back-to-back strobes apart
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, e);
		addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		chk("rdata", e, rdata_o);
		tick(1);
	endtask
	task automatic step(input logic [3:0] s, input logic u);
		stp_i = s;
		up_i = u;
		step_i = 1'b1;
		tick(1);
		step_i = 1'b0;
		tick(1);
	endtask
	// rel waits for reset release, else for the hold to drop
	task automatic wait_low(input logic rel);
		n = 0;
		while ((rel ? rst_n_o !== 1'b1 : hold_o !== 1'b0)
			&& n < 70000) begin
			tick(1);
			n++;
		end
		if (n == 70000) begin
			$display("BAD wait exp done got stuck");
			err_total++;
		end
	endtask
	task automatic t_regs;
		rd(8'h92, 8'h00);
		rd(8'h97, 8'h00);
		rd(8'h98, 8'h08);
		rd(8'h99, 8'h00);
		wr(8'h97, 8'h5a);
		rd(8'h97, 8'h5a);
		rd(8'h9a, 8'h00);
		$display("regs done");
	endtask
	task automatic t_pause;
		wr(8'h92, 8'h53);
		for (int d = 0; d < 4; d++) begin
			for (int u = 0; u < 2; u++) begin
				wr(8'h97, {d[1:0], 6'h11});
				step(4'h3, u[0]);
				chk("hold", {7'h0, d[1 - u]}, {7'h0, hold_o});
				wait_low(1'b0);
			end
		end
		for (int c = 1; c < 4; c++) begin
			wr(8'h97, {4'hd, c[3:0]});
			step(4'h3, 1'b1);
			wait_low(1'b0);
			rng("ptime", (32 << c) - 3, (32 << c) + 3, n);
		end
		wr(8'h97, 8'hd0);
		step(4'h3, 1'b1);
		chk("hold", 8'h00, {7'h0, hold_o});
		wr(8'h97, 8'hd1);
		step(4'h4, 1'b1);
		chk("hold", 8'h00, {7'h0, hold_o});
		$display("pause done");
	endtask
	task automatic t_ext;
		wr(8'h97, 8'hc0);
		lag = 16'h0028;
		step(4'h3, 1'b0);
		chk("hold", 8'h01, {7'h0, hold_o});
		ready = 1'b1;
		wait_low(1'b0);
		rng("sync", 38, 44, n);
		lag = 16'h0000;
		step(4'h3, 1'b1);
		chk("hold", 8'h00, {7'h0, hold_o});
		ready = 1'b0;
		wr(8'h97, 8'he0);
		step(4'h3, 1'b1);
		wait_low(1'b0);
		rng("tmo", 62494, 62504, n);
		$display("ext done");
	endtask
	task automatic t_rst(input int e, input logic [5:0] v, input int x);
		wr(8'h99, {e[1:0], v});
		enter_i = 1'b1;
		tick(1);
		enter_i = 1'b0;
		ev_p = 4'h1 << ((e + 1) % 4);
		tick(1);
		ev_p = 4'h0;
		tick(2);
		chk("rstn", 8'h00, {7'h0, rst_n_o});
		ev_p = 4'h1 << e;
		tick(1);
		ev_p = 4'h0;
		wait_low(1'b1);
		rng("rel", x, x + 3, n);
		$display("rst done");
	endtask
	task automatic t_clk;
		wr(8'h98, 8'he8);
		osc_on_i = 1'b1;
		step(4'h5, 1'b1);
		for (int i = 0; i < 16; i++) begin
			logic p;
			// sample mid-cycle, clear of the oscillator's own update
			@(negedge clock_i) p = osc_i;
			tick(1);
			chk("rtc", {7'h0, p}, {7'h0, rtc_o});
			chk("out", {7'h0, p}, {7'h0, out_o});
		end
		wr(8'h98, 8'he9);
		osc_on_i = 1'b0;
		tick(2);
		osc_on_i = 1'b1;
		for (int i = 0; i < 40; i++) begin
			tick(1);
			chk("rtc", 8'h00, {7'h0, rtc_o});
			chk("out", 8'h00, {7'h0, out_o});
		end
		wr(8'h98, 8'h68);
		step(4'h5, 1'b0);
		for (int i = 0; i < 16; i++) begin
			tick(1);
			chk("rtc", 8'h00, {7'h0, rtc_o});
		end
		$display("clock done");
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		{rst_b_i, reg_wr_i, reg_rd_i, step_i, up_i, enter_i} = 6'h00;
		{addr_i, wdata_i, stp_i, ev_p, osc_on_i, ready} = 26'h0;
		lag = 16'h0000;
		err_total = 0;
		tests_run = 0;
		tick(6);
		rst_b_i = 1'b1;
		tick(1);
		t_regs;
		t_pause;
		t_ext;
		for (int e = 0; e < 4; e++)
			t_rst(e, 6'd0, 0);
		t_rst(1, 6'd1, 127);
		t_rst(2, 6'd32, 4095);
		t_clk;
		close_out;
	end
	initial begin
		#1000000;
		err_total++;
		close_out;
	end
endmodule // sps_timing_ctrl_tb
`default_nettype wire
